// >>> hdl/dtc_timer_unit.sv
// Purpose: one count unit with 13-bit, 16-bit and 8-bit reload modes
// Assumes: step pulses are at least two cycles apart
// Notes: split mode holds the count
`timescale 1ns/1ps
module dtc_timer_unit #(
  parameter int BYTE_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  dtc_cnt_if.unit bus
);
  dtc_pkg::dtc_unit_state_t st_ff;
  dtc_pkg::dtc_unit_state_t nxt_st;

  // the count bytes are fixed at eight bits by the register map
  if (BYTE_W != 8) begin : g_bad_width
    $error("dtc_timer_unit: BYTE_W must be 8");
  end

  // count step, then software byte writes override the value
  always_comb begin
    nxt_st = st_ff;
    nxt_st.roll = 1'b0;
    if (bus.step) begin
      unique case (bus.mode)
        dtc_pkg::DTC_MODE13: begin
          nxt_st.lo[4:0] = st_ff.lo[4:0] + 5'h01;
          if (&st_ff.lo[4:0]) begin
            nxt_st.hi = st_ff.hi + 8'h01;
            nxt_st.roll = &st_ff.hi;
          end
        end
        dtc_pkg::DTC_MODE16: begin
          nxt_st.lo = st_ff.lo + 8'h01;
          if (&st_ff.lo) begin
            nxt_st.hi = st_ff.hi + 8'h01;
            nxt_st.roll = &st_ff.hi;
          end
        end
        dtc_pkg::DTC_MODE8R: begin
          if (&st_ff.lo) begin
            nxt_st.lo = st_ff.hi;
            nxt_st.roll = 1'b1;
          end else begin
            nxt_st.lo = st_ff.lo + 8'h01;
          end
        end
        dtc_pkg::DTC_SPLIT: begin
          nxt_st.lo = st_ff.lo;
        end
      endcase
    end
    // write wins over a step in the same cycle so software loads are exact
    if (bus.wr_lo) begin
      nxt_st.lo = bus.wdata;
    end
    if (bus.wr_hi) begin
      nxt_st.hi = bus.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus.lo = st_ff.lo;
  assign bus.hi = st_ff.hi;
  assign bus.roll = st_ff.roll;

  sequence s_quiet;
    !bus.wr_lo && !bus.wr_hi;
  endsequence
  sequence s_top13;
    bus.step && bus.mode == dtc_pkg::DTC_MODE13 && st_ff.lo[4:0] == 5'h1f && st_ff.hi == 8'hff;
  endsequence
  sequence s_top8;
    bus.step && bus.mode == dtc_pkg::DTC_MODE8R && st_ff.lo == 8'hff;
  endsequence

  chk_mode0_wrap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (s_top13 and s_quiet) |=> (st_ff.lo[4:0] == 5'h00 && st_ff.hi == 8'h00 && st_ff.roll))
    else $error("13-bit count did not wrap with a roll");
  chk_mode1_wrap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (bus.step && bus.mode == dtc_pkg::DTC_MODE16 && {st_ff.hi, st_ff.lo} == 16'hffff) and s_quiet
    |=> ({st_ff.hi, st_ff.lo} == 16'h0000 && st_ff.roll))
    else $error("16-bit count did not wrap with a roll");
  chk_mode2_reload: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (s_top8 and s_quiet) |=> (st_ff.lo == $past(st_ff.hi) && st_ff.roll ##1 !st_ff.roll))
    else $error("8-bit count did not reload from the high byte");
endmodule

// >>> hdl/dtc_top.sv
// Purpose: two timer/counters with run control, overflow flags and
//   external-interrupt edge/level flag logic behind the cpu register port
// Assumes: pins are synchronous to clk_i but still pass two flops;
//   vector acknowledges are one-cycle pulses from the interrupt controller
// Notes: read data appears one cycle after the address is presented
// Contract
// - timer one overflow sets its flag; vectoring to its handler clears it
// - timer zero overflow sets its flag; vectoring to its handler clears it
// - each timer counts only while its run bit is one
// - edge type: falling pin edge sets interrupt-one flag; vectoring or software clears
// - level type: interrupt-one flag follows low pin; software writes ignored
// - interrupt-one type bit picks edge when one, low level when zero
// - edge type: falling pin edge sets interrupt-zero flag; vectoring or software clears
// - level type: interrupt-zero flag follows low pin; software writes ignored
// - interrupt-zero type bit picks edge when one, low level when zero
// - mode 0 counts thirteen bits: five low-byte bits plus high byte
// - counter/timer select picks divided clock or external count pin transitions
// - gate zero counts always; gate one counts only while interrupt pin high
// - mode 0 wraps past all ones to zero and sets overflow flag
// - each rollover drives the overflow pulse pin high for one cycle
// - mode 1 counts sixteen bits and wraps to zero past all ones
// - mode 2 low byte counts eight bits, high byte holds reload value
// - mode 2 overflow loads the high byte into the low byte
// - two-bit mode field selects 13-bit, 16-bit, 8-bit reload or split
// - timer use counts clock divided by four or twelve per prescale bit
// - gate set needs interrupt pin high and run bit; else run only
`timescale 1ns/1ps
`include "dtc_params.svh"
module dtc_top #(
  parameter int SLOW_DIV = `DTC_DIV_SLOW,
  parameter int FAST_DIV = `DTC_DIV_FAST
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic [1:0] ack_ovf_i,
  input wire logic [1:0] ack_ext_i,
  input wire logic extint_zero_pin_n_i,
  input wire logic extint_one_pin_n_i,
  input wire logic count_pin_zero_i,
  input wire logic count_pin_one_i,
  output logic overflow_pulse_zero_o,
  output logic overflow_pulse_one_o,
  output logic [1:0] ovf_flag_o,
  output logic [1:0] ext_flag_o
);
  dtc_pkg::dtc_top_state_t st_ff;
  dtc_pkg::dtc_top_state_t nxt_st;
  logic tick_slow;
  logic tick_fast;
  logic [1:0] src_tick;
  logic [1:0] step_w;
  logic [1:0] gate_ok;
  logic [1:0] roll_w;
  logic [1:0] cnt_fall;
  logic [1:0] ext_fall;
  logic [7:0] lo_w [2];
  logic [7:0] hi_w [2];

  // the fast tick is carved out of the slow counter, so the rates must nest
  if (SLOW_DIV % FAST_DIV != 0 || SLOW_DIV > 16 || FAST_DIV < 2 || (FAST_DIV & (FAST_DIV - 1)) != 0)
  begin : g_bad_div
    $error("dtc_top: SLOW_DIV must be a multiple of a power-of-two FAST_DIV, at most 16");
  end

  // address match, shared by the write strobes and the read mux
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  // next value of one external-interrupt flag
  function automatic logic ext_next(input logic cur, input logic edge_type, input logic wr,
    input logic wbit, input logic ack, input logic fall, input logic pin_n);
    logic v;
    v = cur;
    if (!edge_type) begin
      v = !pin_n;
    end else begin
      if (wr) begin
        v = wbit;
      end
      if (ack) begin
        v = 1'b0;
      end
      if (fall) begin
        v = 1'b1; // set wins over a clear in the same cycle
      end
    end
    ext_next = v;
  endfunction

  // prescale ticks, one-cycle pulses from the shared divider
  assign tick_slow = (st_ff.pre == 4'(SLOW_DIV - 1));
  assign tick_fast = (4'(st_ff.pre % 4'(FAST_DIV)) == 4'(FAST_DIV - 1));

  // falling edges are taken from the second and third flops only
  assign cnt_fall = st_ff.cnt_s3 & ~st_ff.cnt_s2;
  assign ext_fall = st_ff.ext_s3 & ~st_ff.ext_s2;

  for (genvar i = 0; i < 2; i++) begin : g_timer
    dtc_cnt_if cif ();
    logic [3:0] nib;
    logic run;

    assign nib = st_ff.mode[i * `DTC_MODE_NIB_W +: `DTC_MODE_NIB_W];
    assign run = st_ff.ctrl[`DTC_CTRL_RUN_BASE + `DTC_CTRL_STRIDE * i];

    // source select: external transitions or the chosen clock division
    assign src_tick[i] = nib[`DTC_MODE_CT] ? cnt_fall[i] :
      (st_ff.cksel[`DTC_CKSEL_PRE_BASE + i] ? tick_fast : tick_slow);
    // gate compares with the synchronised pin, so it lags the pin by two cycles
    assign gate_ok[i] = !nib[`DTC_MODE_GATE] || st_ff.ext_s2[i];
    assign step_w[i] = run && gate_ok[i] && src_tick[i];

    assign cif.mode = dtc_pkg::dtc_mode_t'(nib[1:0]);
    assign cif.step = step_w[i];
    assign cif.wr_lo = sfr_wr_i && hit(sfr_addr_i, 8'(`DTC_ADDR_LOW0 + i));
    assign cif.wr_hi = sfr_wr_i && hit(sfr_addr_i, 8'(`DTC_ADDR_HIGH0 + i));
    assign cif.wdata = sfr_wdata_i;
    assign lo_w[i] = cif.lo;
    assign hi_w[i] = cif.hi;
    assign roll_w[i] = cif.roll;

    dtc_timer_unit #(
      .BYTE_W(8)
    ) u_unit (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .bus(cif.unit)
    );
  end

  // synchronisers, divider, register writes and the registered read mux
  always_comb begin
    logic wr_ctrl;
    logic v;
    int op;
    int ep;
    int tp;
    int rp;
    wr_ctrl = sfr_wr_i && hit(sfr_addr_i, `DTC_ADDR_CTRL);
    v = 1'b0;
    op = 0;
    ep = 0;
    tp = 0;
    rp = 0;
    nxt_st = st_ff;
    nxt_st.ext_s1 = {extint_one_pin_n_i, extint_zero_pin_n_i};
    nxt_st.ext_s2 = st_ff.ext_s1;
    nxt_st.ext_s3 = st_ff.ext_s2;
    nxt_st.cnt_s1 = {count_pin_one_i, count_pin_zero_i};
    nxt_st.cnt_s2 = st_ff.cnt_s1;
    nxt_st.cnt_s3 = st_ff.cnt_s2;
    nxt_st.pre = tick_slow ? 4'h0 : st_ff.pre + 4'h1;
    if (sfr_wr_i && hit(sfr_addr_i, `DTC_ADDR_MODE)) begin
      nxt_st.mode = sfr_wdata_i;
    end
    if (sfr_wr_i && hit(sfr_addr_i, `DTC_ADDR_CKSEL)) begin
      nxt_st.cksel = sfr_wdata_i;
    end
    for (int i = 0; i < 2; i++) begin
      op = `DTC_CTRL_OVF_BASE + `DTC_CTRL_STRIDE * i;
      rp = `DTC_CTRL_RUN_BASE + `DTC_CTRL_STRIDE * i;
      ep = `DTC_CTRL_EXT_BASE + `DTC_CTRL_STRIDE * i;
      tp = `DTC_CTRL_TYPE_BASE + `DTC_CTRL_STRIDE * i;
      // overflow flag: software write, vector clear, then rollover set wins
      v = st_ff.ctrl[op];
      if (wr_ctrl) begin
        v = sfr_wdata_i[op];
      end
      if (ack_ovf_i[i]) begin
        v = 1'b0;
      end
      if (roll_w[i]) begin
        v = 1'b1;
      end
      nxt_st.ctrl[op] = v;
      if (wr_ctrl) begin
        nxt_st.ctrl[rp] = sfr_wdata_i[rp];
        nxt_st.ctrl[tp] = sfr_wdata_i[tp];
      end
      nxt_st.ctrl[ep] = ext_next(st_ff.ctrl[ep], st_ff.ctrl[tp], wr_ctrl, sfr_wdata_i[ep],
        ack_ext_i[i], ext_fall[i], st_ff.ext_s2[i]);
    end
    // reads have no side effect; unmapped addresses read as zero
    nxt_st.rdata = 8'h00;
    if (hit(sfr_addr_i, `DTC_ADDR_CTRL)) begin
      nxt_st.rdata = st_ff.ctrl;
    end
    if (hit(sfr_addr_i, `DTC_ADDR_MODE)) begin
      nxt_st.rdata = st_ff.mode;
    end
    if (hit(sfr_addr_i, `DTC_ADDR_CKSEL)) begin
      nxt_st.rdata = st_ff.cksel;
    end
    for (int i = 0; i < 2; i++) begin
      // in mode 0 the top three low-byte bits are left as last written
      if (hit(sfr_addr_i, 8'(`DTC_ADDR_LOW0 + i))) begin
        nxt_st.rdata = lo_w[i];
      end
      if (hit(sfr_addr_i, 8'(`DTC_ADDR_HIGH0 + i))) begin
        nxt_st.rdata = hi_w[i];
      end
    end
  end

  // pins idle high, so the synchronisers reset to one to avoid a false edge
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= '0;
      st_ff.ext_s1 <= 2'h3;
      st_ff.ext_s2 <= 2'h3;
      st_ff.ext_s3 <= 2'h3;
      st_ff.cnt_s1 <= 2'h3;
      st_ff.cnt_s2 <= 2'h3;
      st_ff.cnt_s3 <= 2'h3;
      st_ff.ctrl <= `DTC_RST_CTRL;
      st_ff.mode <= `DTC_RST_MODE;
      st_ff.cksel <= `DTC_RST_CKSEL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs, all straight from flops
  assign sfr_rdata_o = st_ff.rdata;
  assign overflow_pulse_zero_o = roll_w[0];
  assign overflow_pulse_one_o = roll_w[1];
  assign ovf_flag_o = {st_ff.ctrl[`DTC_CTRL_OVF1], st_ff.ctrl[`DTC_CTRL_OVF0]};
  assign ext_flag_o = {st_ff.ctrl[`DTC_CTRL_EXT1], st_ff.ctrl[`DTC_CTRL_EXT0]};

  // building blocks of the multi-step checks
  sequence s_slow_gap;
    (!tick_slow) [*8];
  endsequence

  sequence s_edge_one;
    st_ff.ctrl[`DTC_CTRL_TYPE1] && ext_fall[1];
  endsequence

  sequence s_edge_zero;
    st_ff.ctrl[`DTC_CTRL_TYPE0] && ext_fall[0];
  endsequence

  // overflow flags: a rollover sets, a vector acknowledge clears
  chk_ovf_one_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    roll_w[1] |=> st_ff.ctrl[`DTC_CTRL_OVF1] && overflow_pulse_one_o == 1'b0)
    else $error("timer one rollover did not set its flag");

  chk_ovf_zero_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    roll_w[0] |=> st_ff.ctrl[`DTC_CTRL_OVF0])
    else $error("timer zero rollover did not set its flag");

  chk_ovf_ack_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ack_ovf_i[0] && !roll_w[0] |=> !st_ff.ctrl[`DTC_CTRL_OVF0])
    else $error("vector acknowledge did not clear timer zero flag");

  chk_ovf_one_ack: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ack_ovf_i[1] && !roll_w[1] |=> !st_ff.ctrl[`DTC_CTRL_OVF1])
    else $error("vector acknowledge did not clear timer one flag");

  // run, gate and count source; the gate sees the pin two cycles late
  chk_run_gates_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    step_w[0] |-> st_ff.ctrl[`DTC_CTRL_RUN0])
    else $error("timer zero stepped with run bit clear");

  chk_run_one_gates: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    step_w[1] |-> st_ff.ctrl[`DTC_CTRL_RUN1])
    else $error("timer one stepped with run bit clear");

  chk_gate_blocks_count: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_ff.mode[`DTC_MODE_NIB_W + `DTC_MODE_GATE] && !st_ff.ext_s2[1] |-> !step_w[1])
    else $error("timer one stepped while gated off");

  chk_gate_zero_blocks: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_ff.mode[`DTC_MODE_GATE] && !st_ff.ext_s2[0] |-> !step_w[0])
    else $error("timer zero stepped while gated off");

  chk_count_source: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    step_w[1] && st_ff.mode[`DTC_MODE_NIB_W + `DTC_MODE_CT] |-> cnt_fall[1])
    else $error("counter use stepped without a pin transition");

  chk_count_src_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    step_w[0] && st_ff.mode[`DTC_MODE_CT] |-> cnt_fall[0])
    else $error("timer zero counter use stepped without a pin transition");

  chk_prescale_gap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tick_slow |=> s_slow_gap ##1 (!tick_slow) [*3] ##1 tick_slow)
    else $error("slow prescale tick not every twelve cycles");

  chk_slow_src_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    step_w[0] && !st_ff.mode[`DTC_MODE_CT] && !st_ff.cksel[`DTC_CKSEL_PRE_BASE] |-> tick_slow)
    else $error("timer zero stepped off the slow tick");

  // split mode is not served here, so a timer left in it must never roll over
  chk_split_zero_holds: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_ff.mode[1:0] == 2'h3 |=> !roll_w[0])
    else $error("timer zero rolled over in split mode");

  chk_split_one_holds: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_ff.mode[`DTC_MODE_NIB_W +: 2] == 2'h3 |=> !roll_w[1])
    else $error("timer one rolled over in split mode");

  // external-interrupt flags, edge and level type
  chk_edge_one_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_edge_one |=> st_ff.ctrl[`DTC_CTRL_EXT1])
    else $error("falling edge did not set interrupt-one flag");

  chk_edge_zero_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_edge_zero |=> st_ff.ctrl[`DTC_CTRL_EXT0])
    else $error("falling edge did not set interrupt-zero flag");

  chk_ext_one_ack: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_ff.ctrl[`DTC_CTRL_TYPE1] && ack_ext_i[1] && !ext_fall[1] |=> !st_ff.ctrl[`DTC_CTRL_EXT1])
    else $error("vector acknowledge did not clear interrupt-one flag");

  chk_ext_zero_ack: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_ff.ctrl[`DTC_CTRL_TYPE0] && ack_ext_i[0] && !ext_fall[0] |=> !st_ff.ctrl[`DTC_CTRL_EXT0])
    else $error("vector acknowledge did not clear interrupt-zero flag");

  chk_level_one_follow: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !st_ff.ctrl[`DTC_CTRL_TYPE1] |=> st_ff.ctrl[`DTC_CTRL_EXT1] == !$past(st_ff.ext_s2[1]))
    else $error("level interrupt-one flag did not follow the pin");

  chk_level_zero_follow: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !st_ff.ctrl[`DTC_CTRL_TYPE0] |=> st_ff.ctrl[`DTC_CTRL_EXT0] == !$past(st_ff.ext_s2[0]))
    else $error("level interrupt-zero flag did not follow the pin");

  // edge detection and pulse widths
  chk_edge_once: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cnt_fall[0] |-> ($past(count_pin_zero_i, 3) && !$past(count_pin_zero_i, 2)) ##1 !cnt_fall[0])
    else $error("count pin edge seen without a pin fall or seen twice");

  chk_pulse_width: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(overflow_pulse_zero_o) |=> !overflow_pulse_zero_o)
    else $error("overflow pulse longer than one cycle");

  chk_pulse_one_width: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(overflow_pulse_one_o) |=> !overflow_pulse_one_o)
    else $error("timer one overflow pulse longer than one cycle");
endmodule

// >>> include/dtc_cnt_if.sv
// Purpose: link between the control logic and one count unit
// Assumes: single clock domain
// Notes: step is a one-cycle pulse per count event
`timescale 1ns/1ps
interface dtc_cnt_if;
  dtc_pkg::dtc_mode_t mode;
  logic step;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] wdata;
  logic [7:0] lo;
  logic [7:0] hi;
  logic roll;
  modport ctl (output mode, output step, output wr_lo, output wr_hi, output wdata,
    input lo, input hi, input roll);
  modport unit (input mode, input step, input wr_lo, input wr_hi, input wdata,
    output lo, output hi, output roll);
endinterface

// >>> include/dtc_params.svh
// Purpose: constants of the dual timer/counter and external-interrupt block
// Assumes: 8-bit special function register port inside the cpu core
// Notes: timer one fields sit one stride above timer zero fields
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH
// register offsets
`define DTC_ADDR_CTRL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_LOW0 8'h8a
`define DTC_ADDR_HIGH0 8'h8c
`define DTC_ADDR_CKSEL 8'h8e
// control register fields, timer or pin i at base + 2*i
`define DTC_CTRL_TYPE_BASE 0
`define DTC_CTRL_EXT_BASE 1
`define DTC_CTRL_RUN_BASE 4
`define DTC_CTRL_OVF_BASE 5
`define DTC_CTRL_STRIDE 2
`define DTC_CTRL_TYPE0 0
`define DTC_CTRL_EXT0 1
`define DTC_CTRL_TYPE1 2
`define DTC_CTRL_EXT1 3
`define DTC_CTRL_RUN0 4
`define DTC_CTRL_OVF0 5
`define DTC_CTRL_RUN1 6
`define DTC_CTRL_OVF1 7
// mode register nibble per timer
`define DTC_MODE_NIB_W 4
`define DTC_MODE_GATE 3
`define DTC_MODE_CT 2
// clock select register, prescale select of timer i at base + i
`define DTC_CKSEL_PRE_BASE 3
// reset values
`define DTC_RST_CTRL 8'h00
`define DTC_RST_MODE 8'h00
`define DTC_RST_CKSEL 8'h01
// prescale counts in cpu clocks
`define DTC_DIV_SLOW 12
`define DTC_DIV_FAST 4
`endif

// >>> include/dtc_pkg.sv
// Purpose: types of the dual timer/counter block
// Assumes: dtc_params.svh holds every number
// Notes: none
package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_MODE13 = 2'h0,
    DTC_MODE16 = 2'h1,
    DTC_MODE8R = 2'h2,
    DTC_SPLIT = 2'h3
  } dtc_mode_t;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic roll;
  } dtc_unit_state_t;

  typedef struct packed {
    logic [1:0] ext_s1;
    logic [1:0] ext_s2;
    logic [1:0] ext_s3;
    logic [1:0] cnt_s1;
    logic [1:0] cnt_s2;
    logic [1:0] cnt_s3;
    logic [3:0] pre;
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] cksel;
    logic [7:0] rdata;
  } dtc_top_state_t;
endpackage

// >>> verification/dtc_cpu_model.sv
// Purpose: cpu-side model that vectors to the handler of a raised timer or pin flag
// Assumes: flag_i bits 1:0 are overflow flags, bits 3:2 external-interrupt flags
// Notes: an enabled flag gets one acknowledge pulse after dly_i idle cycles
`timescale 1ns/1ps
module dtc_cpu_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] flag_i,
  input wire logic [3:0] en_i,
  input wire logic [3:0] dly_i,
  output logic [3:0] ack_o
);
  logic [3:0] cnt_ff [4];

  // a slow core is modelled by the wait; while the flag stays up the pulse repeats every dly_i + 2 cycles
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_o <= 4'h0;
      for (int i = 0; i < 4; i++) cnt_ff[i] <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        ack_o[i] <= 1'b0;
        if (flag_i[i] && en_i[i] && !ack_o[i]) begin
          if (cnt_ff[i] == dly_i) begin
            ack_o[i] <= 1'b1;
            cnt_ff[i] <= 4'h0;
          end else begin
            cnt_ff[i] <= cnt_ff[i] + 4'h1;
          end
        end else begin
          cnt_ff[i] <= 4'h0;
        end
      end
    end
  end
endmodule

// >>> verification/dtc_top_tb_top.sv
// Purpose: self-checking bench for the dual timer/counter through its register port
// Assumes: read data is valid one cycle after the address is sampled
// Notes: pulses are sampled on the falling clock edge, where they are settled
`timescale 1ns/1ps
module dtc_top_tb_top;
  logic clk_i, rst_b_i, sfr_wr_i;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, tb, fb;
  logic [1:0] ext_n, cnt_pin, ovf_flag_o, ext_flag_o, pls;
  logic [3:0] ack, ack_en, ack_dly, flags;
  int n_mismatch = 0, checks = 0, cyc = 0, k, b;
  int np[2], last[2], gap[2];

  dtc_top #(.SLOW_DIV(12), .FAST_DIV(4)) i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .ack_ovf_i(ack[1:0]),
    .ack_ext_i(ack[3:2]), .extint_zero_pin_n_i(ext_n[0]), .extint_one_pin_n_i(ext_n[1]),
    .count_pin_zero_i(cnt_pin[0]), .count_pin_one_i(cnt_pin[1]), .overflow_pulse_zero_o(pls[0]),
    .overflow_pulse_one_o(pls[1]), .ovf_flag_o(ovf_flag_o), .ext_flag_o(ext_flag_o));

  dtc_cpu_model i_cpu (.clk_i(clk_i), .rst_b_i(rst_b_i), .flag_i({ext_flag_o, ovf_flag_o}), .en_i(ack_en),
    .dly_i(ack_dly), .ack_o(ack));
  assign flags = {ext_flag_o, ovf_flag_o};

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // pulse counting and spacing; a pulse stretched to two cycles is counted twice
  always @(negedge clk_i) begin
    cyc++;
    for (int p = 0; p < 2; p++) begin
      if (pls[p] === 1'b1) begin
        gap[p] = cyc - last[p];
        last[p] = cyc;
        np[p]++;
      end
    end
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one write strobe; the write is taken at the second edge
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_wr_i <= 1'b1;
    sfr_wdata_i <= d;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
  endtask

  // read with mask m, compared against e
  task automatic rc(string n, logic [7:0] a, logic [7:0] m, logic [7:0] e);
    @(posedge clk_i);
    sfr_addr_i <= a;
    @(posedge clk_i);
    #1;
    chk(n, sfr_rdata_o & m, e);
  endtask

  // one falling transition on a count pin, held long past the synchroniser
  task automatic fall(int i);
    cnt_pin[i] <= 1'b0;
    idle(5);
    cnt_pin[i] <= 1'b1;
    idle(5);
  endtask

  // let the core vector to flag i after d cycles, bounded wait for the flag to drop
  task automatic ackw(int i, logic [3:0] d);
    ack_dly <= d;
    ack_en[i] <= 1'b1;
    for (k = 0; k < 30 && flags[i] !== 1'b0; k++) @(posedge clk_i);
    ack_en <= 4'h0;
    @(posedge clk_i);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    rst_b_i = 1'b0;
    sfr_addr_i = 8'h00;
    sfr_wr_i = 1'b0;
    sfr_wdata_i = 8'h00;
    ext_n = 2'h3;
    cnt_pin = 2'h3;
    ack_en = 4'h0;
    ack_dly = 4'h0;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    // reset values and an unmapped address
    rc("ctrl reset", 8'h88, 8'hff, 8'h00);
    rc("mode reset", 8'h89, 8'hff, 8'h00);
    rc("cksel reset", 8'h8e, 8'hff, 8'h01);
    rc("unmapped", 8'h8f, 8'hff, 8'h00);
    // timer zero, 8-bit reload, counting pin transitions
    wr(8'h89, 8'h06);
    wr(8'h8c, 8'hf0);
    wr(8'h8a, 8'hfe);
    wr(8'h88, 8'h10);
    b = np[0];
    fall(0);
    rc("low0 step", 8'h8a, 8'hff, 8'hff);
    fall(0);
    rc("low0 reload", 8'h8a, 8'hff, 8'hf0);
    chk("pulse0 count", 8'(np[0] - b), 8'h01);
    rc("ctrl flag0", 8'h88, 8'hff, 8'h30);
    ackw(0, 4'h0);
    chk("flag0 vectored", {7'h0, ovf_flag_o[0]}, 8'h00);
    // timer one, 13-bit count: carry out of bit 4 and full wrap
    wr(8'h89, 8'h40);
    wr(8'h88, 8'h40);
    for (int j = 0; j < 2; j++) begin
      wr(8'h8b, 8'h1f);
      wr(8'h8d, j ? 8'hff : 8'h12);
      b = np[1];
      fall(1);
      rc("low1 masked", 8'h8b, 8'h1f, 8'h00);
      rc("high1", 8'h8d, 8'hff, j ? 8'h00 : 8'h13);
      chk("flag1", {7'h0, ovf_flag_o[1]}, 8'(j));
      chk("pulse1 count", 8'(np[1] - b), 8'(j));
    end
    ackw(1, 4'h0);
    chk("flag1 vectored", {7'h0, ovf_flag_o[1]}, 8'h00);
    // timer zero, 16-bit wrap on the divided clock
    wr(8'h89, 8'h01);
    wr(8'h8a, 8'hff);
    wr(8'h8c, 8'hff);
    b = np[0];
    wr(8'h88, 8'h10);
    for (k = 0; k < 40 && np[0] == b; k++) @(posedge clk_i);
    rc("high0 wrap", 8'h8c, 8'hff, 8'h00);
    rc("low0 wrap", 8'h8a, 8'hff, 8'h00);
    chk("flag0 mode1", {7'h0, ovf_flag_o[0]}, 8'h01);
    wr(8'h88, 8'h00);
    ackw(0, 4'h0);
    // prescale rates: reload of 0xff overflows on every step
    wr(8'h89, 8'h02);
    wr(8'h8c, 8'hff);
    wr(8'h8a, 8'hff);
    for (int j = 0; j < 2; j++) begin
      wr(8'h8e, j ? 8'h09 : 8'h01);
      wr(8'h88, 8'h10);
      idle(45);
      chk("gap0", 8'(gap[0]), j ? 8'h04 : 8'h0c);
      wr(8'h88, 8'h00);
    end
    idle(3);
    b = np[0];
    idle(30);
    chk("run off", 8'(np[0] - b), 8'h00);
    wr(8'h89, 8'h03);
    wr(8'h88, 8'h10);
    b = np[0];
    idle(30);
    chk("split holds", 8'(np[0] - b), 8'h00);
    wr(8'h88, 8'h00);
    // timer one gate: pin low blocks counting only with the gate bit set
    wr(8'h8e, 8'h11);
    wr(8'h8d, 8'hff);
    wr(8'h8b, 8'hff);
    ext_n[1] <= 1'b0;
    for (int g = 0; g < 2; g++) begin
      wr(8'h89, g ? 8'ha0 : 8'h20);
      wr(8'h88, 8'h40);
      idle(3);
      b = np[1];
      idle(30);
      chk("gate count", {7'h0, np[1] != b}, {7'h0, g == 0});
    end
    ext_n[1] <= 1'b1;
    b = np[1];
    idle(30);
    chk("gate open", {7'h0, np[1] != b}, 8'h01);
    chk("gap1", 8'(gap[1]), 8'h04);
    wr(8'h88, 8'h00);
    ackw(1, 4'h0);
    // external-interrupt flags, edge then level type, for each pin
    for (int i = 0; i < 2; i++) begin
      tb = 8'h01 << (2 * i);
      fb = tb << 1;
      wr(8'h88, tb);
      ext_n[i] <= 1'b0;
      idle(6);
      chk("edge set", {7'h0, ext_flag_o[i]}, 8'h01);
      rc("ctrl ext flag", 8'h88, fb, fb);
      wr(8'h88, tb);
      idle(6);
      chk("sw clear held low", {7'h0, ext_flag_o[i]}, 8'h00);
      ext_n[i] <= 1'b1;
      idle(4);
      ext_n[i] <= 1'b0;
      idle(6);
      chk("edge again", {7'h0, ext_flag_o[i]}, 8'h01);
      ackw(2 + i, 4'h7);
      chk("edge vectored", {7'h0, ext_flag_o[i]}, 8'h00);
      wr(8'h88, 8'h00);
      idle(5);
      chk("level low", {7'h0, ext_flag_o[i]}, 8'h01);
      wr(8'h88, 8'h00);
      idle(2);
      chk("level sw clear", {7'h0, ext_flag_o[i]}, 8'h01);
      ext_n[i] <= 1'b1;
      idle(5);
      chk("level high", {7'h0, ext_flag_o[i]}, 8'h00);
      wr(8'h88, fb);
      idle(2);
      chk("level sw set", {7'h0, ext_flag_o[i]}, 8'h00);
    end
    final_report();
  end
endmodule
